// ---- citd_code_mem.sv ----
// Program memory fetch pointer model
`timescale 1ns/10ps

module citd_code_mem
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Fetch release
	input wire logic exec_done,
	input wire logic [1:0] pc_advance,
	// Fetch address
	output logic [15:0] fetch_addr
);
always @(posedge core_clk)
begin
	if (reset)
		fetch_addr <= 16'h0000;
	else if (exec_done)
		fetch_addr <= fetch_addr + {14'h0000, pc_advance};
end
endmodule

// ---- citd_core.v ----
// Instruction length and execution cycle sequencer
//
// How it works
// - Register to accumulator move: one byte, one cycle.
// - Direct to direct byte move: three bytes, four cycles.
// - Data pointer immediate load: three bytes, three cycles.
// - Code byte read indexed by accumulator: one byte, four cycles.
// - On-chip auxiliary RAM moves: one byte, three cycles, any address width.
// - External RAM moves: one byte, three to twenty cycles by stretch setting.
// - Bus mode clear: five plus twice latch, pulse, twice setup/hold stretch.
// - Bus mode set: three plus pulse stretch plus twice setup/hold stretch.
// - Push: two bytes, four cycles; pop: two bytes, three cycles.
// - Low nibble exchange with indirect RAM: one byte, four cycles.
// - Immediate add, add with carry, subtract: two bytes, two cycles.
// - Logic op of immediate into direct byte: three bytes, four cycles.
// - Accumulator rotates, with or without carry: one byte, one cycle.
// - Accumulator nibble swap: one byte, one cycle.
// - Carry combined with bit or complement: two bytes, three cycles.
// - Branch on bit set and clear: three bytes, five cycles, clears if taken.
// - Interrupt return: one byte, four cycles, like plain return.
// - Indirect jump on accumulator plus pointer: one byte, three cycles.
// - Compare indirect RAM with immediate, branch: three bytes, five cycles.
// - Decrement direct byte, branch if nonzero: three bytes, five cycles.
// - Immediate to direct byte move: three bytes, three cycles.
`timescale 1ns/10ps
`include "citd_regs.vh"

module citd_core
(
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Instruction request
	input wire inst_valid,
	input wire [5:0] inst_class,
	input wire aux_external,
	input wire branch_taken,
	// External bus stretch configuration
	input wire ext_bus_mode_bit,
	input wire [1:0] ale_stretch,
	input wire [2:0] rw_stretch,
	input wire rdwr_setup_hold_stretch,
	// Sequencer status
	output reg inst_ready,
	output reg exec_busy,
	output reg exec_done,
	output reg [1:0] pc_advance,
	output reg [4:0] exec_cycles,
	output reg [4:0] cycles_left,
	output reg bit_clear,
	output reg class_unknown,
	output reg ext_access
);

// ---------------------------------------------------------------
// Class cost lookup
// ---------------------------------------------------------------
reg [6:0] cost;
reg known;

always @*
begin
	cost = `CITD_COST_1_1;
	known = 1'h1;
	case (inst_class)
		`CITD_CLS_MOV_A_REG: cost = `CITD_COST_1_1;
		`CITD_CLS_MOV_A_DIR: cost = `CITD_COST_2_2;
		`CITD_CLS_MOV_A_IND: cost = `CITD_COST_1_2;
		`CITD_CLS_MOV_A_IMM: cost = `CITD_COST_2_2;
		`CITD_CLS_MOV_REG_A: cost = `CITD_COST_1_2;
		`CITD_CLS_MOV_DIR_DIR: cost = `CITD_COST_3_4;
		`CITD_CLS_MOV_DIR_IMM: cost = `CITD_COST_3_3;
		`CITD_CLS_MOV_IND_A: cost = `CITD_COST_1_3;
		`CITD_CLS_LOAD_DATA_POINTER: cost = `CITD_COST_3_3;
		`CITD_CLS_CODE_READ: cost = `CITD_COST_1_4;
		`CITD_CLS_AUX_MOVE: cost = `CITD_COST_1_3;
		`CITD_CLS_PUSH: cost = `CITD_COST_2_4;
		`CITD_CLS_POP: cost = `CITD_COST_2_3;
		`CITD_CLS_XCH_REG: cost = `CITD_COST_1_3;
		`CITD_CLS_NIBBLE_XCHG: cost = `CITD_COST_1_4;
		`CITD_CLS_ARITH_IMM: cost = `CITD_COST_2_2;
		`CITD_CLS_ARITH_REG: cost = `CITD_COST_1_2;
		`CITD_CLS_ARITH_DIR: cost = `CITD_COST_2_3;
		`CITD_CLS_INC_DIR: cost = `CITD_COST_2_4;
		`CITD_CLS_INC_DATA_POINTER: cost = `CITD_COST_1_1;
		`CITD_CLS_MUL: cost = `CITD_COST_1_4;
		`CITD_CLS_DIV: cost = `CITD_COST_1_5;
		`CITD_CLS_DEC_ADJ: cost = `CITD_COST_1_4;
		`CITD_CLS_LOGIC_DIR_IMM: cost = `CITD_COST_3_4;
		`CITD_CLS_LOGIC_DIR_A: cost = `CITD_COST_2_4;
		`CITD_CLS_ROTATE: cost = `CITD_COST_1_1;
		`CITD_CLS_NIBBLE_SWAP: cost = `CITD_COST_1_1;
		`CITD_CLS_CARRY_OP: cost = `CITD_COST_1_1;
		`CITD_CLS_BIT_MODIFY: cost = `CITD_COST_2_4;
		`CITD_CLS_CARRY_BIT_LOGIC: cost = `CITD_COST_2_3;
		`CITD_CLS_JUMP_BIT: cost = `CITD_COST_3_4;
		`CITD_CLS_BRANCH_BIT_CLEAR: cost = `CITD_COST_3_5;
		`CITD_CLS_ABS_CALL: cost = `CITD_COST_2_6;
		`CITD_CLS_LONG_CALL: cost = `CITD_COST_3_6;
		`CITD_CLS_RETURN: cost = `CITD_COST_1_4;
		`CITD_CLS_INTERRUPT_RETURN: cost = `CITD_COST_1_4;
		`CITD_CLS_INDIRECT_JUMP: cost = `CITD_COST_1_3;
		`CITD_CLS_SHORT_JUMP: cost = `CITD_COST_2_3;
		`CITD_CLS_LONG_JUMP: cost = `CITD_COST_3_4;
		`CITD_CLS_COMPARE_BRANCH_IND: cost = `CITD_COST_3_5;
		`CITD_CLS_COMPARE_BRANCH_IMM: cost = `CITD_COST_3_4;
		`CITD_CLS_DEC_BRANCH_DIR: cost = `CITD_COST_3_5;
		`CITD_CLS_DEC_BRANCH_REG: cost = `CITD_COST_2_4;
		`CITD_CLS_NOP: cost = `CITD_COST_1_1;
		default: known = 1'h0;
	endcase
end

// ---------------------------------------------------------------
// External access length
// ---------------------------------------------------------------
wire [4:0] ext_len;

citd_xcalc u_xcalc
(
	.ext_bus_mode_bit(ext_bus_mode_bit),
	.ale_stretch(ale_stretch),
	.rw_stretch(rw_stretch),
	.rdwr_setup_hold_stretch(rdwr_setup_hold_stretch),
	.ext_cycles(ext_len)
);

// ---------------------------------------------------------------
// Resolved length of the requested instruction
// ---------------------------------------------------------------
wire is_aux;
wire is_ext;
wire [1:0] req_bytes;
wire [4:0] req_cycles;

assign is_aux = (inst_class == `CITD_CLS_AUX_MOVE);
assign is_ext = is_aux & aux_external;
assign req_bytes = cost[6:5];
assign req_cycles = is_ext ? ext_len : cost[4:0];

// ---------------------------------------------------------------
// Sequencer
// ---------------------------------------------------------------
reg state;
reg clear_pending;
reg next_state;
wire accept;
wire last_cycle;

assign accept = (state == `CITD_ST_IDLE) & inst_valid;
assign last_cycle = (state == `CITD_ST_EXEC) & (cycles_left == 5'h01);

always @*
begin
	next_state = state;
	case (state)
		`CITD_ST_IDLE:
		begin
			if (inst_valid)
			begin
				next_state = `CITD_ST_EXEC;
			end
		end
		`CITD_ST_EXEC:
		begin
			if (cycles_left == 5'h01)
			begin
				next_state = `CITD_ST_IDLE;
			end
		end
		default: next_state = `CITD_ST_IDLE;
	endcase
end

always @(posedge core_clk)
begin
	if (reset)
	begin
		state <= `CITD_ST_IDLE;
		inst_ready <= 1'h1;
		exec_busy <= 1'h0;
		exec_done <= 1'h0;
		pc_advance <= 2'h0;
		exec_cycles <= 5'h00;
		cycles_left <= 5'h00;
		bit_clear <= 1'h0;
		class_unknown <= 1'h0;
		ext_access <= 1'h0;
		clear_pending <= 1'h0;
	end
	else
	begin
		state <= next_state;
		exec_done <= 1'h0;
		bit_clear <= 1'h0;
		if (accept)
		begin
			inst_ready <= 1'h0;
			exec_busy <= 1'h1;
			pc_advance <= req_bytes;
			exec_cycles <= req_cycles;
			cycles_left <= req_cycles;
			class_unknown <= ~known;
			ext_access <= is_ext;
			clear_pending <= (inst_class == `CITD_CLS_BRANCH_BIT_CLEAR) & branch_taken;
		end
		else if (state == `CITD_ST_EXEC)
		begin
			cycles_left <= cycles_left - 5'h01;
			if (last_cycle)
			begin
				exec_busy <= 1'h0;
				exec_done <= 1'h1;
				inst_ready <= 1'h1;
				ext_access <= 1'h0;
				bit_clear <= clear_pending;
				clear_pending <= 1'h0;
			end
		end
	end
end

endmodule

// ---- citd_core_assertions.sv ----
// Timing checks on the sequencer ports
`timescale 1ns/10ps
`include "citd_regs.vh"

module citd_core_assertions
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Request
	input wire logic inst_valid,
	input wire logic [5:0] inst_class,
	input wire logic aux_external,
	input wire logic ext_bus_mode_bit,
	input wire logic [1:0] ale_stretch,
	input wire logic [2:0] rw_stretch,
	input wire logic rdwr_setup_hold_stretch,
	// Status
	input wire logic inst_ready,
	input wire logic exec_busy,
	input wire logic exec_done,
	input wire logic [1:0] pc_advance,
	input wire logic [4:0] exec_cycles,
	input wire logic [4:0] cycles_left,
	input wire logic bit_clear,
	input wire logic ext_access
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (reset);
wire logic acc = inst_valid && inst_ready;
wire logic aux = acc && inst_class == `CITD_CLS_AUX_MOVE;
// ---------------------------------------------------------------
// Assertions
// ---------------------------------------------------------------
a_accept_starts_busy: assert property (acc |=> exec_busy && !inst_ready && cycles_left == exec_cycles)
	else $error("busy not started");
a_count_steps_down: assert property (exec_busy && cycles_left > 5'h01 |=> exec_busy && cycles_left == $past(cycles_left) - 5'h01)
	else $error("bad countdown");
a_release_fetch: assert property (exec_busy && cycles_left == 5'h01 |=> exec_done && inst_ready && !exec_busy ##1 !exec_done)
	else $error("bad release");
a_reg_move_cost: assert property (acc && inst_class == `CITD_CLS_MOV_A_REG |=> pc_advance == 2'h1 && exec_cycles == 5'h01)
	else $error("bad register move cost");
a_onchip_aux_cost: assert property (aux && !aux_external |=> exec_cycles == 5'h03 && pc_advance == 2'h1 && !ext_access)
	else $error("bad on-chip cost");
a_ext_mux_cost: assert property (aux && aux_external && !ext_bus_mode_bit |=> ext_access &&
	exec_cycles == 5 + 2 * $past(ale_stretch) + $past(rw_stretch) + 2 * $past(rdwr_setup_hold_stretch))
	else $error("bad mode 0 cost");
a_ext_demux_cost: assert property (aux && aux_external && ext_bus_mode_bit |=> ext_access &&
	exec_cycles == 3 + $past(rw_stretch) + 2 * $past(rdwr_setup_hold_stretch))
	else $error("bad mode 1 cost");
a_ext_cost_range: assert property (ext_access |-> exec_cycles >= 5'h03 && exec_cycles <= 5'h14)
	else $error("external cost out of range");
a_bit_clear_end: assert property (bit_clear |-> exec_done && exec_cycles == 5'h05)
	else $error("stray bit clear");
c_ext_access: cover property (aux && aux_external);
c_bit_clear: cover property (bit_clear);
c_back_to_back: cover property (exec_done && acc);
endmodule

bind citd_core citd_core_assertions i_citd_core_assertions (.core_clk(core_clk), .reset(reset),
	.inst_valid(inst_valid), .inst_class(inst_class), .aux_external(aux_external),
	.ext_bus_mode_bit(ext_bus_mode_bit), .ale_stretch(ale_stretch), .rw_stretch(rw_stretch),
	.rdwr_setup_hold_stretch(rdwr_setup_hold_stretch), .inst_ready(inst_ready), .exec_busy(exec_busy),
	.exec_done(exec_done), .pc_advance(pc_advance), .exec_cycles(exec_cycles), .cycles_left(cycles_left),
	.bit_clear(bit_clear), .ext_access(ext_access));

// ---- citd_regs.vh ----
// Constants for the instruction timing sequencer
`ifndef CITD_REGS_VH
`define CITD_REGS_VH

// ---------------------------------------------------------------
// Field widths
// ---------------------------------------------------------------
`define CITD_CLS_W 6
`define CITD_BYTES_W 2
`define CITD_CYC_W 5
`define CITD_COST_W 7

// ---------------------------------------------------------------
// External access cycle bases
// ---------------------------------------------------------------
`define CITD_XBASE_MUX 5'h05
`define CITD_XBASE_DEMUX 5'h03

// ---------------------------------------------------------------
// Sequencer states
// ---------------------------------------------------------------
`define CITD_ST_IDLE 1'h0
`define CITD_ST_EXEC 1'h1

// ---------------------------------------------------------------
// Instruction class codes
// ---------------------------------------------------------------
`define CITD_CLS_MOV_A_REG 6'h00
`define CITD_CLS_MOV_A_DIR 6'h01
`define CITD_CLS_MOV_A_IND 6'h02
`define CITD_CLS_MOV_A_IMM 6'h03
`define CITD_CLS_MOV_REG_A 6'h04
`define CITD_CLS_MOV_DIR_DIR 6'h05
`define CITD_CLS_MOV_DIR_IMM 6'h06
`define CITD_CLS_MOV_IND_A 6'h07
`define CITD_CLS_LOAD_DATA_POINTER 6'h08
`define CITD_CLS_CODE_READ 6'h09
`define CITD_CLS_AUX_MOVE 6'h0a
`define CITD_CLS_PUSH 6'h0b
`define CITD_CLS_POP 6'h0c
`define CITD_CLS_XCH_REG 6'h0d
`define CITD_CLS_NIBBLE_XCHG 6'h0e
`define CITD_CLS_ARITH_IMM 6'h0f
`define CITD_CLS_ARITH_REG 6'h10
`define CITD_CLS_ARITH_DIR 6'h11
`define CITD_CLS_INC_DIR 6'h12
`define CITD_CLS_INC_DATA_POINTER 6'h13
`define CITD_CLS_MUL 6'h14
`define CITD_CLS_DIV 6'h15
`define CITD_CLS_DEC_ADJ 6'h16
`define CITD_CLS_LOGIC_DIR_IMM 6'h17
`define CITD_CLS_LOGIC_DIR_A 6'h18
`define CITD_CLS_ROTATE 6'h19
`define CITD_CLS_NIBBLE_SWAP 6'h1a
`define CITD_CLS_CARRY_OP 6'h1b
`define CITD_CLS_BIT_MODIFY 6'h1c
`define CITD_CLS_CARRY_BIT_LOGIC 6'h1d
`define CITD_CLS_JUMP_BIT 6'h1e
`define CITD_CLS_BRANCH_BIT_CLEAR 6'h1f
`define CITD_CLS_ABS_CALL 6'h20
`define CITD_CLS_LONG_CALL 6'h21
`define CITD_CLS_RETURN 6'h22
`define CITD_CLS_INTERRUPT_RETURN 6'h23
`define CITD_CLS_INDIRECT_JUMP 6'h24
`define CITD_CLS_SHORT_JUMP 6'h25
`define CITD_CLS_LONG_JUMP 6'h26
`define CITD_CLS_COMPARE_BRANCH_IND 6'h27
`define CITD_CLS_COMPARE_BRANCH_IMM 6'h28
`define CITD_CLS_DEC_BRANCH_DIR 6'h29
`define CITD_CLS_DEC_BRANCH_REG 6'h2a
`define CITD_CLS_NOP 6'h2b

// ---------------------------------------------------------------
// Costs as {bytes, cycles}
// ---------------------------------------------------------------
`define CITD_COST_1_1 {2'h1, 5'h01}
`define CITD_COST_1_2 {2'h1, 5'h02}
`define CITD_COST_1_3 {2'h1, 5'h03}
`define CITD_COST_1_4 {2'h1, 5'h04}
`define CITD_COST_1_5 {2'h1, 5'h05}
`define CITD_COST_2_2 {2'h2, 5'h02}
`define CITD_COST_2_3 {2'h2, 5'h03}
`define CITD_COST_2_4 {2'h2, 5'h04}
`define CITD_COST_2_6 {2'h2, 5'h06}
`define CITD_COST_3_3 {2'h3, 5'h03}
`define CITD_COST_3_4 {2'h3, 5'h04}
`define CITD_COST_3_5 {2'h3, 5'h05}
`define CITD_COST_3_6 {2'h3, 5'h06}

`endif

// ---- citd_xcalc.v ----
// External auxiliary RAM access cycle calculator
`timescale 1ns/10ps
`include "citd_regs.vh"

module citd_xcalc
(
	// Stretch configuration
	input wire ext_bus_mode_bit,
	input wire [1:0] ale_stretch,
	input wire [2:0] rw_stretch,
	input wire rdwr_setup_hold_stretch,
	// Result
	output reg [4:0] ext_cycles
);

// ---------------------------------------------------------------
// Cycle sum
// ---------------------------------------------------------------
wire [4:0] ale_term;
wire [4:0] rw_term;
wire [4:0] sh_term;

assign ale_term = {2'h0, ale_stretch, 1'h0};
assign rw_term = {2'h0, rw_stretch};
assign sh_term = {3'h0, rdwr_setup_hold_stretch, 1'h0};

always @*
begin
	if (ext_bus_mode_bit)
	begin
		ext_cycles = `CITD_XBASE_DEMUX + rw_term + sh_term;
	end
	else
	begin
		ext_cycles = `CITD_XBASE_MUX + ale_term + rw_term + sh_term;
	end
end

endmodule

// ---- cpu_instruction_timing_tb_top.sv ----
// Testbench for the instruction timing sequencer
`timescale 1ns/10ps
`include "citd_regs.vh"
`define CHK(a, e) begin comparisons = comparisons + 1; if ((a) !== (e)) begin miscompares = miscompares + 1; \
	$display("unexpected at %0t: %h vs %h", $time, a, e); end end

module cpu_instruction_timing_tb_top;
logic core_clk = 1'b0;
logic reset = 1'b1;
logic inst_valid = 1'b0;
logic [5:0] inst_class = 6'h00;
logic aux_external = 1'b0, branch_taken = 1'b0, ext_bus_mode_bit = 1'b0, rdwr_setup_hold_stretch = 1'b0;
logic [1:0] ale_stretch = 2'h0;
logic [2:0] rw_stretch = 3'h0;
wire logic inst_ready, exec_busy, exec_done, bit_clear, class_unknown, ext_access;
wire logic [1:0] pc_advance;
wire logic [4:0] exec_cycles, cycles_left;
wire logic [15:0] fetch_addr;
logic [15:0] exp_pc = 16'h0000;
integer miscompares = 0, comparisons = 0, cyc = 0;

citd_core i_citd_core (.core_clk(core_clk), .reset(reset), .inst_valid(inst_valid), .inst_class(inst_class),
	.aux_external(aux_external), .branch_taken(branch_taken), .ext_bus_mode_bit(ext_bus_mode_bit),
	.ale_stretch(ale_stretch), .rw_stretch(rw_stretch), .rdwr_setup_hold_stretch(rdwr_setup_hold_stretch),
	.inst_ready(inst_ready), .exec_busy(exec_busy), .exec_done(exec_done), .pc_advance(pc_advance),
	.exec_cycles(exec_cycles), .cycles_left(cycles_left), .bit_clear(bit_clear),
	.class_unknown(class_unknown), .ext_access(ext_access));
citd_code_mem i_citd_code_mem (.core_clk(core_clk), .reset(reset), .exec_done(exec_done),
	.pc_advance(pc_advance), .fetch_addr(fetch_addr));

always #10 core_clk = ~core_clk;

// ---------------------------------------------------------------
// Shared tasks
// ---------------------------------------------------------------
task tally_and_finish;
begin
	$display("comparisons %0d miscompares %0d", comparisons, miscompares);
	if (miscompares == 0 && comparisons > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
end
endtask

// One instruction: cfg is {aux_ext, taken, mode, ale, rw, sh}
task automatic run(input [5:0] c, input [8:0] cfg, input [1:0] b, input [4:0] n);
	integer k;
begin
	k = 0;
	while (inst_ready !== 1'b1) @(negedge core_clk);
	@(posedge core_clk);
	inst_valid <= 1'b1;
	inst_class <= c;
	{aux_external, branch_taken, ext_bus_mode_bit, ale_stretch, rw_stretch, rdwr_setup_hold_stretch} <= cfg;
	@(posedge core_clk);
	inst_valid <= 1'b0;
	@(negedge core_clk);
	`CHK({ext_access, cycles_left}, {cfg[8] & (c == `CITD_CLS_AUX_MOVE), n})
	`CHK(class_unknown, (c > `CITD_CLS_NOP))
	while (exec_busy === 1'b1 && k < 40)
	begin
		k = k + 1;
		@(negedge core_clk);
	end
	exp_pc = exp_pc + b;
	`CHK(k, n)
	`CHK(pc_advance, b)
	`CHK(exec_cycles, n)
	`CHK(exec_done, 1'b1)
	`CHK(bit_clear, cfg[7])
end
endtask

// ---------------------------------------------------------------
// Scenarios
// ---------------------------------------------------------------
task t_moves;
begin
	run(`CITD_CLS_MOV_A_REG, 9'h000, 2'h1, 5'h01);
	run(`CITD_CLS_MOV_DIR_DIR, 9'h000, 2'h3, 5'h04);
	run(`CITD_CLS_LOAD_DATA_POINTER, 9'h000, 2'h3, 5'h03);
	run(`CITD_CLS_CODE_READ, 9'h000, 2'h1, 5'h04);
	run(`CITD_CLS_PUSH, 9'h000, 2'h2, 5'h04);
	run(`CITD_CLS_POP, 9'h000, 2'h2, 5'h03);
	run(`CITD_CLS_NIBBLE_XCHG, 9'h000, 2'h1, 5'h04);
	run(`CITD_CLS_MOV_DIR_IMM, 9'h000, 2'h3, 5'h03);
end
endtask

task t_alu;
begin
	run(`CITD_CLS_ARITH_IMM, 9'h000, 2'h2, 5'h02);
	run(`CITD_CLS_LOGIC_DIR_IMM, 9'h000, 2'h3, 5'h04);
	run(`CITD_CLS_ROTATE, 9'h000, 2'h1, 5'h01);
	run(`CITD_CLS_NIBBLE_SWAP, 9'h000, 2'h1, 5'h01);
	run(`CITD_CLS_CARRY_BIT_LOGIC, 9'h000, 2'h2, 5'h03);
	run(6'h3f, 9'h000, 2'h1, 5'h01);
end
endtask

task t_branch;
begin
	run(`CITD_CLS_BRANCH_BIT_CLEAR, 9'h080, 2'h3, 5'h05);
	run(`CITD_CLS_BRANCH_BIT_CLEAR, 9'h000, 2'h3, 5'h05);
	run(`CITD_CLS_INTERRUPT_RETURN, 9'h000, 2'h1, 5'h04);
	run(`CITD_CLS_RETURN, 9'h000, 2'h1, 5'h04);
	run(`CITD_CLS_INDIRECT_JUMP, 9'h000, 2'h1, 5'h03);
	run(`CITD_CLS_COMPARE_BRANCH_IND, 9'h000, 2'h3, 5'h05);
	run(`CITD_CLS_DEC_BRANCH_DIR, 9'h000, 2'h3, 5'h05);
end
endtask

task t_aux;
begin
	run(`CITD_CLS_AUX_MOVE, 9'h03f, 2'h1, 5'h03);
	run(`CITD_CLS_AUX_MOVE, 9'h100, 2'h1, 5'h05);
	run(`CITD_CLS_AUX_MOVE, 9'h114, 2'h1, 5'h09);
	run(`CITD_CLS_AUX_MOVE, 9'h13f, 2'h1, 5'h14);
	run(`CITD_CLS_AUX_MOVE, 9'h140, 2'h1, 5'h03);
	run(`CITD_CLS_AUX_MOVE, 9'h17f, 2'h1, 5'h0c);
end
endtask

// Second request held during busy, taken at the edge after the release edge
task t_b2b;
begin
	while (inst_ready !== 1'b1) @(negedge core_clk);
	@(posedge core_clk);
	inst_valid <= 1'b1;
	inst_class <= `CITD_CLS_MOV_DIR_IMM;
	{aux_external, branch_taken} <= 2'h0;
	@(posedge core_clk);
	inst_class <= `CITD_CLS_ROTATE;
	repeat (3) @(posedge core_clk);
	@(negedge core_clk);
	`CHK({exec_done, exec_cycles}, {1'b1, 5'h03})
	@(posedge core_clk);
	inst_valid <= 1'b0;
	@(negedge core_clk);
	`CHK({exec_busy, pc_advance, exec_cycles}, {1'b1, 2'h1, 5'h01})
	exp_pc = exp_pc + 16'h0004;
end
endtask

always @(posedge core_clk)
begin
	cyc = cyc + 1;
	if (cyc == 2000)
	begin
		miscompares = miscompares + 1;
		tally_and_finish;
	end
end

initial
begin
	repeat (6) @(posedge core_clk);
	reset <= 1'b0;
	t_moves;
	t_alu;
	t_branch;
	t_aux;
	t_b2b;
	while (inst_ready !== 1'b1) @(negedge core_clk);
	@(negedge core_clk);
	`CHK(fetch_addr, exp_pc)
	tally_and_finish;
end
endmodule
